// ==== iac_top.sv ====
// Digital back end of a multi-slope integrating converter: sequencer, results
// counter, result and status bytes, pin outputs and the serial command link.
// Assumes an analog front end providing comparator crossing and polarity levels.
//
// Contract
// - Command byte with bit zero set writes the pin-output command register.
// - Command bits seven..four drive general outputs three..zero until the next write.
// - Result is the raw accumulated count; no zero reading is subtracted.
// - Low byte holds result bits 3..10, select code 00, fresh after end-of-conversion.
// - High byte holds result bits 11..18, twos complement, sign one for negatives.
// - Result bits 2..0 sit in the status byte, refreshed each conversion end.
// - Integrating flag is one exactly during the input integration phase.
// - At end-of-conversion the converter idles in zero-integrate at count zero.
// - A cycle spans 2048 counts; end flag set at count zero, cleared at one.
// - Result update during a frame sets collision at that frame's chip-select rise.
// - Reading the status byte clears the collision flag.
// - Binary sequence counter starts and stops integration at preset counts.
// - Each deintegration starts at a fixed count and ends early on zero crossing.
// - Up/down results counter accumulates in deintegration, direction from polarity.
// - Counter step is 512, 64, 8 and 1 in the four deintegration phases.
// - At every conversion end the counter is copied into the results register.
// - Result magnitude saturates at the hard overrange limit of 350440.
// - Result bit eighteen is kept as a nineteenth magnitude bit.
// - Select code picks next read byte: low, high, status; code three invalid.
// - Bytes move MSB first, in on rising, out on falling, taken at chip-select rise.
`include "iac_regs.svh"
module iac_top
    import iac_pkg::*;
(
    // Converter clock and reset
    input wire logic clk,
    input wire logic resetn,
    // Serial link
    input wire logic sclk,
    input wire logic cs_n,
    input wire logic din,
    output logic dout,
    // Analog front end
    input wire logic comp_cross,
    input wire logic comp_neg,
    output logic integrating,
    output logic deint_active,
    output logic deint_neg,
    output logic read_zero,
    output logic sleep_mode,
    output logic eoc,
    // General outputs
    output logic general_out_zero,
    output logic general_out_one,
    output logic general_out_two,
    output logic general_out_three
);
    typedef struct packed {
        logic cs_s1;
        logic cs_s2;
        logic cs_prev;
        logic cross_s1;
        logic cross_s2;
        logic neg_s1;
        logic neg_s2;
        iac_phase_t phase;
        logic [10:0] seq_cnt;
        logic [1:0] de_idx;
        logic [20:0] acc;
        logic dir_neg;
        logic [19:0] result;
        logic start_pend;
        logic mode50;
        logic sleep_bit;
        logic sleeping;
        logic rd_zero;
        iac_sel_t rsel;
        iac_sel_t sent_sel;
        logic [3:0] pins;
        logic collision;
        logic upd_in_frame;
        logic [7:0] tx_byte;
        logic eoc;
        logic out_int;
        logic out_deint;
        logic out_neg;
    } iac_state_t;

    iac_state_t st_reg;
    iac_state_t st_next;
    logic [7:0] rx_byte;
    logic [7:0] status_byte;

    iac_serial u_serial (
        .sclk(sclk),
        .cs_n(cs_n),
        .din(din),
        .dout(dout),
        .resetn(resetn),
        .tx_byte(st_reg.tx_byte),
        .rx_byte(rx_byte)
    );

    // Fixed start and end counts of each deintegration window
    function automatic logic [10:0] de_start(input logic [1:0] idx);
        case (idx)
            2'h0: de_start = `IAC_DE1_START;
            2'h1: de_start = `IAC_DE2_START;
            2'h2: de_start = `IAC_DE3_START;
            default: de_start = `IAC_DE4_START;
        endcase
    endfunction : de_start

    function automatic logic [10:0] de_end(input logic [1:0] idx);
        case (idx)
            2'h0: de_end = `IAC_DE_END_1;
            2'h1: de_end = `IAC_DE_END_2;
            2'h2: de_end = `IAC_DE_END_3;
            default: de_end = `IAC_DE_END_4;
        endcase
    endfunction : de_end

    // Step shrinks by eight per phase: 512, 64, 8, 1
    function automatic logic [20:0] de_step(input logic [1:0] idx);
        de_step = `IAC_STEP_1 >> (5'd3 * {3'h0, idx});
    endfunction : de_step

    // Clip to the hard overrange limit in either direction
    function automatic logic [19:0] clip(input logic [20:0] v);
        logic signed [20:0] sv;
        sv = signed'(v);
        if (sv > signed'(`IAC_HARD_LIMIT)) begin
            clip = 20'(`IAC_HARD_LIMIT);
        end else if (sv < -signed'(`IAC_HARD_LIMIT)) begin
            clip = 20'(-`IAC_HARD_LIMIT);
        end else begin
            clip = v[19:0];
        end
    endfunction : clip

    assign status_byte = {st_reg.collision, st_reg.eoc, st_reg.out_int, st_reg.sleeping,
                          st_reg.result[19], st_reg.result[2:0]};

    always_comb begin
        logic cs_rise;
        logic cs_fall;
        logic [10:0] int_start;
        logic [10:0] int_stop;
        logic latch;
        logic [7:0] cmd;
        cs_rise = 1'b0;
        cs_fall = 1'b0;
        int_start = '0;
        int_stop = '0;
        latch = 1'b0;
        cmd = rx_byte;
        st_next = st_reg;

        // Synchronisers for the chip select and comparator levels
        st_next.cs_s1 = cs_n;
        st_next.cs_s2 = st_reg.cs_s1;
        st_next.cs_prev = st_reg.cs_s2;
        st_next.cross_s1 = comp_cross;
        st_next.cross_s2 = st_reg.cross_s1;
        st_next.neg_s1 = comp_neg;
        st_next.neg_s2 = st_reg.neg_s1;
        cs_rise = st_reg.cs_s2 & ~st_reg.cs_prev;
        cs_fall = ~st_reg.cs_s2 & st_reg.cs_prev;

        // Integration window depends on line-frequency mode
        if (st_reg.mode50) begin
            int_start = `IAC_PRE_ZI_50 + 11'h001;
            int_stop = `IAC_PRE_ZI_50 + `IAC_INT_LEN_50;
        end else begin
            int_start = `IAC_PRE_ZI_60 + 11'h001;
            int_stop = `IAC_PRE_ZI_60 + `IAC_INT_LEN_60;
        end

        // Sequence counter advances in every phase but idle
        if (st_reg.phase != PH_IDLE) begin
            st_next.seq_cnt = st_reg.seq_cnt + 11'h001;
        end

        case (st_reg.phase)
            PH_IDLE: begin
                st_next.seq_cnt = '0;
                st_next.sleeping = st_reg.sleep_bit;
                if (st_reg.start_pend) begin
                    st_next.phase = PH_PRE;
                    st_next.seq_cnt = 11'h001;
                    st_next.start_pend = 1'b0;
                    st_next.acc = '0;
                    st_next.sleeping = 1'b0;
                end
            end
            PH_PRE: begin
                if (st_reg.seq_cnt == int_start - 11'h001) begin
                    st_next.phase = PH_INTEG;
                end
            end
            PH_INTEG: begin
                if (st_reg.seq_cnt == int_stop) begin
                    st_next.phase = PH_WAIT;
                end
            end
            PH_WAIT, PH_REST: begin
                if (st_reg.phase == PH_REST && st_reg.de_idx == 2'h3) begin
                    if (st_reg.seq_cnt == `IAC_DE_END_4) begin
                        st_next.phase = PH_FINAL;
                    end
                end else if (st_reg.seq_cnt == de_start(st_next.de_idx) - 11'h001) begin
                    st_next.phase = PH_DEINT;
                    st_next.dir_neg = st_reg.neg_s2;
                end
                if (st_reg.phase == PH_WAIT) begin
                    st_next.de_idx = 2'h0;
                end
            end
            PH_DEINT: begin
                if (!st_reg.cross_s2) begin
                    if (st_reg.dir_neg) begin
                        st_next.acc = st_reg.acc - de_step(st_reg.de_idx);
                    end else begin
                        st_next.acc = st_reg.acc + de_step(st_reg.de_idx);
                    end
                end
                // A full window leaves no rest: the next window opens on the very next count
                if (st_reg.seq_cnt == de_end(st_reg.de_idx)) begin
                    if (st_reg.de_idx == 2'h3) begin
                        st_next.phase = PH_FINAL;
                    end else begin
                        st_next.phase = PH_DEINT;
                        st_next.de_idx = st_reg.de_idx + 2'h1;
                        st_next.dir_neg = st_reg.neg_s2;
                    end
                end else if (st_reg.cross_s2) begin
                    st_next.phase = PH_REST;
                end
            end
            PH_FINAL: begin
                if (st_reg.seq_cnt == `IAC_SEQ_LAST) begin
                    st_next.phase = PH_IDLE;
                    st_next.seq_cnt = '0;
                    latch = 1'b1;
                end
            end
            default: begin
                st_next.phase = PH_IDLE;
            end
        endcase

        // Next deintegration index advances on leaving each rest after the first three windows
        if (st_reg.phase == PH_REST && st_next.phase == PH_DEINT) begin
            st_next.de_idx = st_reg.de_idx + 2'h1;
        end
        if (st_reg.phase == PH_REST && st_reg.de_idx != 2'h3
            && st_reg.seq_cnt == de_start(st_reg.de_idx + 2'h1) - 11'h001) begin
            st_next.phase = PH_DEINT;
            st_next.de_idx = st_reg.de_idx + 2'h1;
            st_next.dir_neg = st_reg.neg_s2;
        end

        // Raw count, offset included, clipped at the hard limit
        if (latch) begin
            st_next.result = clip(st_reg.acc);
            if (!st_reg.cs_s2) begin
                st_next.upd_in_frame = 1'b1;
            end
        end

        // Phase outputs
        st_next.eoc = (st_next.phase == PH_IDLE);
        st_next.out_int = (st_next.phase == PH_INTEG);
        st_next.out_deint = (st_next.phase == PH_DEINT);
        st_next.out_neg = st_next.dir_neg;

        // Frame start freezes the byte being sent
        if (cs_fall) begin
            st_next.sent_sel = st_reg.rsel;
        end

        // Received byte is taken at the chip-select rise
        if (cs_rise) begin
            if (cmd[`IAC_CMD_SEL_BIT]) begin
                st_next.pins = cmd[`IAC_CMD_PIN_LSB +: 4];
            end else begin
                if (cmd[`IAC_CMD_START_BIT]) begin
                    st_next.start_pend = 1'b1;
                end
                st_next.mode50 = cmd[`IAC_CMD_MODE50_BIT];
                st_next.sleep_bit = cmd[`IAC_CMD_SLEEP_BIT];
                st_next.rd_zero = cmd[`IAC_CMD_RDZERO_BIT];
                st_next.rsel = {cmd[`IAC_CMD_RSHIGH_BIT], cmd[`IAC_CMD_RSLOW_BIT]};
            end
            // Set wins over the clear from a status read
            if (st_reg.upd_in_frame || (latch && !st_reg.cs_s2)) begin
                st_next.collision = 1'b1;
            end else if (st_reg.sent_sel == `IAC_SEL_STATUS) begin
                st_next.collision = 1'b0;
            end
            st_next.upd_in_frame = 1'b0;
        end

        // A start during a conversion waits for the sequence to return to zero
        if (st_reg.phase == PH_IDLE && st_reg.start_pend) begin
            st_next.sleeping = 1'b0;
        end

        // Outgoing byte follows the selection while no frame is running
        if (st_reg.cs_s2) begin
            case (st_next.rsel)
                `IAC_SEL_LOW: st_next.tx_byte = st_next.result[10:3];
                `IAC_SEL_HIGH: st_next.tx_byte = st_next.result[18:11];
                `IAC_SEL_STATUS: st_next.tx_byte = status_byte;
                default: st_next.tx_byte = `IAC_INVALID_BYTE;
            endcase
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            st_reg <= '0;
            st_reg.cs_s1 <= 1'b1;
            st_reg.cs_s2 <= 1'b1;
            st_reg.cs_prev <= 1'b1;
            st_reg.phase <= PH_IDLE;
            st_reg.eoc <= 1'b1;
            st_reg.rsel <= `IAC_RST_RSEL;
            st_reg.pins <= `IAC_RST_PINS;
            st_reg.tx_byte <= `IAC_RST_BYTE;
        end else begin
            st_reg <= st_next;
        end
    end

    // Outputs straight from state flops
    assign integrating = st_reg.out_int;
    assign deint_active = st_reg.out_deint;
    assign deint_neg = st_reg.out_neg;
    assign read_zero = st_reg.rd_zero;
    assign sleep_mode = st_reg.sleeping;
    assign eoc = st_reg.eoc;
    assign general_out_zero = st_reg.pins[0];
    assign general_out_one = st_reg.pins[1];
    assign general_out_two = st_reg.pins[2];
    assign general_out_three = st_reg.pins[3];
endmodule : iac_top

// ==== iac_regs.svh ====
// Constants of the integrating converter back end: select codes, field positions,
// reset values and sequence counts. Included by the package and the main module.
`ifndef IAC_REGS_SVH
`define IAC_REGS_SVH

// Read-select codes {read_select_high, read_select_low}
`define IAC_SEL_LOW 2'h0
`define IAC_SEL_HIGH 2'h1
`define IAC_SEL_STATUS 2'h2
`define IAC_SEL_INVALID 2'h3
`define IAC_INVALID_BYTE 8'h00

// Command byte fields
`define IAC_CMD_SEL_BIT 0
`define IAC_CMD_START_BIT 7
`define IAC_CMD_MODE50_BIT 6
`define IAC_CMD_SLEEP_BIT 5
`define IAC_CMD_RDZERO_BIT 4
`define IAC_CMD_RSLOW_BIT 2
`define IAC_CMD_RSHIGH_BIT 1
`define IAC_CMD_PIN_LSB 4

// Status byte fields
`define IAC_ST_COLL_BIT 7
`define IAC_ST_EOC_BIT 6
`define IAC_ST_INT_BIT 5
`define IAC_ST_SLEEP_BIT 4
`define IAC_ST_NEG_BIT 3

// Reset values
`define IAC_RST_PINS 4'h0
`define IAC_RST_RSEL 2'h0
`define IAC_RST_BYTE 8'h00

// Sequence counts (converter clocks); one cycle spans 2048 counts
`define IAC_SEQ_LAST 11'h7ff
`define IAC_PRE_ZI_60 11'h06f
`define IAC_PRE_ZI_50 11'h001
`define IAC_INT_LEN_60 11'h221
`define IAC_INT_LEN_50 11'h28f
`define IAC_DE1_START 11'h320
`define IAC_DE2_START 11'h640
`define IAC_DE3_START 11'h6d6
`define IAC_DE4_START 11'h76c
`define IAC_DE_END_1 11'h63f
`define IAC_DE_END_2 11'h6d5
`define IAC_DE_END_3 11'h76b
`define IAC_DE_END_4 11'h7eb
`define IAC_STEP_1 21'h000200
`define IAC_HARD_LIMIT 21'h0558e8

`endif

// ==== iac_pkg.sv ====
// Types shared by the converter back end modules.
// Assumes iac_regs.svh is on the include path.
package iac_pkg;
`include "iac_regs.svh"

    typedef enum logic [2:0] {
        PH_IDLE,
        PH_PRE,
        PH_INTEG,
        PH_WAIT,
        PH_DEINT,
        PH_REST,
        PH_FINAL
    } iac_phase_t;

    typedef logic [1:0] iac_sel_t;
endpackage : iac_pkg

// ==== iac_serial.sv ====
// Serial link front end on the serial clock: receive shift on rising edges,
// transmit on falling edges. Assumes the serial clock idles high between frames.
module iac_serial
    import iac_pkg::*;
(
    // Link
    input wire logic sclk,
    input wire logic cs_n,
    input wire logic din,
    output logic dout,
    // System
    input wire logic resetn,
    input wire logic [7:0] tx_byte,
    output logic [7:0] rx_byte
);
    typedef struct packed {
        logic [7:0] shift;
    } iac_rx_t;

    typedef struct packed {
        logic [2:0] cnt;
        logic dout;
    } iac_tx_t;

    iac_rx_t rx_reg;
    iac_rx_t rx_next;
    iac_tx_t tx_reg;
    iac_tx_t tx_next;
    logic frame_clr;

    assign frame_clr = cs_n | ~resetn;
    assign rx_byte = rx_reg.shift;
    assign dout = tx_reg.dout;

    always_comb begin
        rx_next = rx_reg;
        if (!cs_n) begin
            rx_next.shift = {rx_reg.shift[6:0], din};
        end
    end

    always_ff @(posedge sclk or negedge resetn) begin
        if (!resetn) begin
            rx_reg <= '0;
        end else begin
            rx_reg <= rx_next;
        end
    end

    // Most significant bit leaves on the first falling edge of the frame
    always_comb begin
        tx_next = tx_reg;
        tx_next.dout = tx_byte[3'h7 - tx_reg.cnt];
        tx_next.cnt = tx_reg.cnt + 3'h1;
    end

    always_ff @(negedge sclk or posedge frame_clr) begin
        if (frame_clr) begin
            tx_reg <= '0;
        end else begin
            tx_reg <= tx_next;
        end
    end
endmodule : iac_serial

// ==== iac_top_properties.sv ====
// Checker for the converter back end: sequencing, flags and pin updates.
// Assumes it is bound to iac_top and sees only that module's ports.
module iac_checker (
    // Clock and reset
    input wire logic clk,
    input wire logic resetn,
    // Link
    input wire logic cs_n,
    input wire logic dout,
    // Converter status
    input wire logic integrating,
    input wire logic deint_active,
    input wire logic sleep_mode,
    input wire logic eoc,
    // General outputs
    input wire logic general_out_zero,
    input wire logic general_out_one,
    input wire logic general_out_two,
    input wire logic general_out_three
);
    default clocking @(posedge clk); endclocking
    default disable iff (!resetn);

    logic [11:0] low_cnt_reg;
    logic [11:0] int_cnt_reg;
    logic [3:0] rise_age_reg;
    logic [1:0] cs_sync_reg;
    logic [3:0] pins;
    assign pins = {general_out_three, general_out_two, general_out_one, general_out_zero};

    // Clocks converting, clocks integrating, clocks since a frame ended
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            low_cnt_reg <= 12'h000;
            int_cnt_reg <= 12'h000;
            rise_age_reg <= 4'hf;
            cs_sync_reg <= 2'h3;
        end else begin
            low_cnt_reg <= eoc ? 12'h000 : low_cnt_reg + 12'h001;
            int_cnt_reg <= integrating ? int_cnt_reg + 12'h001 : 12'h000;
            cs_sync_reg <= {cs_sync_reg[0], cs_n};
            rise_age_reg <= (cs_sync_reg == 2'h1) ? 4'h0 : ((rise_age_reg == 4'hf) ? 4'hf : rise_age_reg + 4'h1);
        end
    end

    sequence conv_start;
        $fell(eoc);
    endsequence

    sequence integ_end;
        $fell(integrating);
    endsequence

    a_cycle_length: assert property ($rose(eoc) |-> low_cnt_reg == 12'h7ff)
        else $error("conversion did not span 2048 counts");
    a_integ_length: assert property (integ_end |-> int_cnt_reg == 12'h221 || int_cnt_reg == 12'h28f)
        else $error("integration length wrong");
    a_integ_after_start: assert property (conv_start |-> ##[1:130] integrating)
        else $error("integration did not begin after start");
    a_deint_follows: assert property (integ_end |-> !deint_active ##[1:300] deint_active)
        else $error("deintegration did not follow integration");
    a_integ_exclusive: assert property (integrating |-> !eoc && !deint_active)
        else $error("integrating flag outside integration");
    a_idle_quiet: assert property (eoc |-> !deint_active)
        else $error("deintegrating while idle");
    a_sleep_idle: assert property (sleep_mode |-> eoc)
        else $error("sleep while converting");
    a_pins_cause: assert property ($changed(pins) |-> rise_age_reg <= 4'h8)
        else $error("general outputs changed without a command");
    a_dout_released: assert property (cs_n [*3] |-> !dout)
        else $error("data out driven while deselected");
endmodule : iac_checker

bind iac_top iac_checker u_chk (
    .clk(clk),
    .resetn(resetn),
    .cs_n(cs_n),
    .dout(dout),
    .integrating(integrating),
    .deint_active(deint_active),
    .sleep_mode(sleep_mode),
    .eoc(eoc),
    .general_out_zero(general_out_zero),
    .general_out_one(general_out_one),
    .general_out_two(general_out_two),
    .general_out_three(general_out_three)
);

// ==== iac_host_model.sv ====
// Host side of the four-wire serial link: one task moves a whole frame.
// Assumes the device samples data in on rising serial clock edges.
module iac_host_model (
    // Link
    output logic sclk,
    output logic cs_n,
    output logic din,
    input wire logic dout
);
    timeunit 1ns;
    timeprecision 1ps;

    initial begin
        sclk = 1'b1;
        cs_n = 1'b1;
        din = 1'b0;
    end

    // Serial clock stands high outside frames; 160 ns period inside
    task automatic xfer(input logic [7:0] cmd, input int lead_ns, output logic [7:0] rsp);
        cs_n = 1'b0;
        #(lead_ns);
        for (int i = 7; i >= 0; i--) begin
            sclk = 1'b0;
            din = cmd[i];
            #80;
            rsp[i] = dout;
            sclk = 1'b1;
            #80;
        end
        cs_n = 1'b1;
        // Released data line must not keep showing the last bit
        din = ~din;
        #400;
    endtask : xfer
endmodule : iac_host_model

// ==== iac_testbench.sv ====
// Testbench: pin commands, two saturated conversions with readback,
// and a collision. Assumes the host model and the bound checker.
`include "iac_regs.svh"
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk;
    logic resetn;
    logic comp_cross;
    logic comp_neg;
    wire sclk;
    wire cs_n;
    wire din;
    wire dout;
    logic integrating;
    logic deint_active;
    logic deint_neg;
    logic read_zero;
    logic sleep_mode;
    logic eoc;
    logic [3:0] pins;
    int fail_count;
    int check_count;
    int cycles;
    // Host's own overrange threshold, just under the raw soft limit
    localparam int soft_limit = 279000;
    logic [7:0] r;
    logic [3:0] pat [4] = '{4'ha, 4'hf, 4'h0, 4'h5};

    iac_top DUT (
        .clk(clk),
        .resetn(resetn),
        .sclk(sclk),
        .cs_n(cs_n),
        .din(din),
        .dout(dout),
        .comp_cross(comp_cross),
        .comp_neg(comp_neg),
        .integrating(integrating),
        .deint_active(deint_active),
        .deint_neg(deint_neg),
        .read_zero(read_zero),
        .sleep_mode(sleep_mode),
        .eoc(eoc),
        .general_out_zero(pins[0]),
        .general_out_one(pins[1]),
        .general_out_two(pins[2]),
        .general_out_three(pins[3])
    );

    iac_host_model u_host (.sclk(sclk), .cs_n(cs_n), .din(din), .dout(dout));

    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    task automatic check8(input string what, input logic [7:0] exp, input logic [7:0] got);
        check_count++;
        if (got !== exp) begin
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
            fail_count++;
        end
    endtask : check8

    task automatic report_and_stop();
        $display("checks %0d, mismatches %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : report_and_stop

    always @(posedge clk) begin
        cycles++;
        if (cycles == 40000) begin
            fail_count++;
            report_and_stop();
        end
    end

    task automatic xf(input logic [7:0] cmd, output logic [7:0] rsp);
        @(negedge clk);
        u_host.xfer(cmd, 200, rsp);
    endtask : xf

    task automatic wait_eoc(input logic lvl);
        int n;
        n = 0;
        while (eoc !== lvl && n < 3000) begin
            @(negedge clk);
            n++;
        end
        check8("eoc level", {7'h0, lvl}, {7'h0, eoc});
    endtask : wait_eoc

    // Uncut: comparator never crosses and the result saturates. Cut: crossing raised
    // as each window opens, seen two counts late, so two steps per window
    task automatic conv(input logic neg, input logic cut, input logic [7:0] cmd);
        logic [19:0] e;
        logic [19:0] got;
        logic [7:0] q;
        int v;
        e = cut ? 20'h00492 : 20'(`IAC_HARD_LIMIT);
        if (neg) begin
            e = -e;
        end
        @(negedge clk);
        comp_neg = neg;
        xf(cmd, q);
        fork
            begin
                wait_eoc(1'b0);
                wait_eoc(1'b1);
            end
            if (cut) begin
                repeat (4) begin
                    @(posedge deint_active);
                    @(negedge clk);
                    comp_cross = 1'b1;
                    @(negedge deint_active);
                    @(negedge clk);
                    comp_cross = 1'b0;
                end
            end
        join
        @(negedge clk);
        check8("read zero", {7'h0, cmd[4]}, {7'h0, read_zero});
        check8("sleep", {7'h0, cmd[5]}, {7'h0, sleep_mode});
        check8("deint sign", {7'h0, neg}, {7'h0, deint_neg});
        xf(8'h04, q);
        got[10:3] = q;
        check8("low byte", e[10:3], q);
        xf(8'h02, q);
        got[18:11] = q;
        check8("high byte", e[18:11], q);
        xf(8'h06, q);
        got[19] = q[3];
        got[2:0] = q[2:0];
        check8("status", {3'h2, 1'b0, e[19], e[2:0]}, q);
        v = {{12{got[19]}}, got};
        check8("overrange", {7'h0, ~cut}, {7'h0, (v > soft_limit) || (v < -soft_limit)});
        xf(8'h00, q);
        check8("invalid select", 8'h00, q);
    endtask : conv

    initial begin
        resetn = 1'b0;
        comp_cross = 1'b0;
        comp_neg = 1'b0;
        repeat (4) @(negedge clk);
        resetn = 1'b1;
        check8("eoc after reset", 8'h01, {7'h0, eoc});
        check8("pins after reset", 8'h00, {4'h0, pins});
        repeat (4) @(negedge clk);
        for (int i = 0; i < 4; i++) begin
            xf({pat[i], 4'h1}, r);
            check8("pins", {4'h0, pat[i]}, {4'h0, pins});
        end
        xf(8'h3c, r);
        check8("pins kept", {4'h0, pat[3]}, {4'h0, pins});
        check8("idle sleep", 8'h01, {7'h0, sleep_mode});
        conv(1'b0, 1'b0, 8'h90);
        conv(1'b1, 1'b0, 8'he0);
        conv(1'b0, 1'b1, 8'h80);
        // Start, read status, then hold a frame open across the latch
        xf(8'h82, r);
        xf(8'h02, r);
        check8("collision before", 8'h00, {7'h0, r[7]});
        repeat (1880) @(negedge clk);
        u_host.xfer(8'h02, 3000, r);
        xf(8'h02, r);
        check8("collision set", 8'h03, {6'h0, r[7:6]});
        xf(8'h00, r);
        check8("collision cleared", 8'h00, {7'h0, r[7]});
        report_and_stop();
    end
endmodule : testbench
